// >>> rtl/mfs_counter.sv
// One free-running 32-bit event counter that wraps and clears on reset only
`timescale 1ns/1ns
module mfs_counter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        inc,
  output logic [31:0]      count
);
  import mfs_pkg::*;

  typedef struct packed {
    logic [31:0] count;
  } mfs_cnt_state_t;

  mfs_cnt_state_t st_reg;
  mfs_cnt_state_t st_next;

  // Plain modulo add: overflow drops the carry, no saturation
  always_comb begin
    st_next = st_reg;
    if (inc) begin
      st_next.count = st_reg.count + 32'h0000_0001;
    end
  end

  // No software path reaches this flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.count <= MFS_RST_COUNT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;

endmodule

// >>> rtl/mfs_pkg.sv
// Package: register map, reset values and carriers of the frame statistics
package mfs_pkg;

  // Data path and address widths, number of counters
  localparam int unsigned MFS_DATA_W = 32;
  localparam int unsigned MFS_ADDR_W = 12;
  localparam int unsigned MFS_NUM_CNT = 3;

  // Byte addresses of the register words
  localparam logic [11:0] MFS_OFS_RSVD_CTRL = 12'h110;
  localparam logic [11:0] MFS_OFS_RX_ALL    = 12'h200;
  localparam logic [11:0] MFS_OFS_RX_GOOD   = 12'h204;
  localparam logic [11:0] MFS_OFS_TX_ALL    = 12'h300;
  localparam logic [11:0] MFS_OFS_STATUS    = 12'h3f0;

  // Values after reset, count maximum and the filled reserved pattern
  localparam logic [31:0] MFS_RST_RSVD_CTRL = 32'h0000_0000;
  localparam logic [31:0] MFS_RST_COUNT     = 32'h0000_0000;
  localparam logic [31:0] MFS_COUNT_MAX     = 32'hffff_ffff;
  localparam logic [31:0] MFS_RSVD_FILLED   = 32'hffff_ffff;
  localparam logic [31:0] MFS_RDATA_NONE    = 32'h0000_0000;

  // Status word field position
  localparam int unsigned MFS_STAT_FILLED_BIT = 0;

  // Counter slots in the counter bank
  localparam int unsigned MFS_CNT_RX_ALL  = 0;
  localparam int unsigned MFS_CNT_RX_GOOD = 1;
  localparam int unsigned MFS_CNT_TX_ALL  = 2;

  // AHB codes used by the slave
  localparam logic [1:0] MFS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] MFS_HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] MFS_HSIZE_HALF    = 3'h1;
  localparam logic       MFS_HRESP_OKAY    = 1'h0;

  // Register selected by an address
  typedef enum logic [2:0] {
    MFS_SEL_NONE,
    MFS_SEL_RSVD,
    MFS_SEL_RX_ALL,
    MFS_SEL_RX_GOOD,
    MFS_SEL_TX_ALL,
    MFS_SEL_STATUS
  } mfs_sel_t;

  // Frame events from the MAC datapath, one-cycle pulses
  typedef struct packed {
    logic rx_done;
    logic rx_valid;
    logic tx_done;
  } mfs_frame_evt_t;

endpackage

// >>> rtl/mfs_stats_top.sv
// Top: AHB-Lite slave holding the MAC frame statistics counter bank
//
// Functional notes
// - The all-received count rises by one for each received frame.
// - The good-received count rises by one only for a valid frame.
// - Counts start at zero and clear only on reset, never by software.
// - A count at its maximum wraps to zero on the next increment.
// - The transmitted-frame count is readable, reset value zero.
// - The transmitted-frame count rises by one per sent frame and wraps.
`timescale 1ns/1ns
module mfs_stats_top (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire mfs_pkg::mfs_frame_evt_t frame_evt,
  output logic [31:0]                  mac_reserved_ctrl
);
  import mfs_pkg::*;

  // Map an address to a register; upper bits must be zero to hit.
  // Byte offsets inside a word hit that word, so sub-word writes land
  function automatic mfs_sel_t reg_sel(input logic [31:0] a);
    mfs_sel_t s;
    s = MFS_SEL_NONE;
    if (a[31:MFS_ADDR_W] == '0) begin
      unique case ({a[11:2], 2'b00})
        MFS_OFS_RSVD_CTRL: s = MFS_SEL_RSVD;
        MFS_OFS_RX_ALL:    s = MFS_SEL_RX_ALL;
        MFS_OFS_RX_GOOD:   s = MFS_SEL_RX_GOOD;
        MFS_OFS_TX_ALL:    s = MFS_SEL_TX_ALL;
        MFS_OFS_STATUS:    s = MFS_SEL_STATUS;
        default:           s = MFS_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Byte lanes touched by a transfer, little-endian lane order
  function automatic logic [3:0] lanes_of(input logic [2:0] sz,
                                          input logic [1:0] a);
    logic [3:0] l;
    l = 4'hf;
    if (sz == MFS_HSIZE_BYTE) begin
      l = 4'h1 << a;
    end else if (sz == MFS_HSIZE_HALF) begin
      l = a[1] ? 4'hc : 4'h3;
    end
    return l;
  endfunction

  // Whole state of the slave
  typedef struct packed {
    mfs_sel_t    wr_sel;
    logic        wr_pend;
    logic [3:0]  wr_lanes;
    logic [31:0] rdata;
    logic [31:0] rsvd;
    logic        ready;
  } mfs_top_state_t;

  mfs_top_state_t st_reg;
  mfs_top_state_t st_next;

  logic [MFS_NUM_CNT-1:0]       cnt_inc;
  logic [MFS_NUM_CNT-1:0][31:0] cnt_val;
  logic                         addr_phase;
  mfs_sel_t                     addr_sel;
  logic [31:0]                  rsvd_now;

  // Event to counter mapping; good frames need the valid flag too
  assign cnt_inc[MFS_CNT_RX_ALL]  = frame_evt.rx_done;
  assign cnt_inc[MFS_CNT_RX_GOOD] = frame_evt.rx_done &
                                    frame_evt.rx_valid;
  assign cnt_inc[MFS_CNT_TX_ALL]  = frame_evt.tx_done;

  // Counter bank; counters have no load or clear input at all
  for (genvar i = 0; i < MFS_NUM_CNT; i++) begin : g_cnt
    mfs_counter u_cnt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (cnt_inc[i]),
      .count   (cnt_val[i])
    );
  end

  // Address phase qualifier
  assign addr_phase = hsel & hready & (htrans == MFS_HTRANS_NONSEQ |
                                       htrans == 2'h3);
  assign addr_sel   = reg_sel(haddr);

  // Reserved word as it stands after a write in this data phase
  always_comb begin
    rsvd_now = st_reg.rsvd;
    if (st_reg.wr_pend && st_reg.wr_sel == MFS_SEL_RSVD) begin
      for (int b = 0; b < 4; b++) begin
        if (st_reg.wr_lanes[b]) begin
          rsvd_now[8*b +: 8] = hwdata[8*b +: 8];
        end
      end
    end
  end

  // Next state: writes land at the end of their data phase, read data
  // is fetched at the end of the address phase so hrdata is a flop
  always_comb begin
    st_next         = st_reg;
    st_next.ready   = 1'b1;
    st_next.rsvd    = rsvd_now;
    st_next.wr_pend = 1'b0;
    // Counter writes fall through: nothing stores them
    if (addr_phase) begin
      st_next.wr_pend  = hwrite;
      st_next.wr_sel   = addr_sel;
      st_next.wr_lanes = lanes_of(hsize, haddr[1:0]);
      st_next.rdata    = MFS_RDATA_NONE;
      if (!hwrite) begin
        unique case (addr_sel)
          MFS_SEL_RSVD:    st_next.rdata = rsvd_now;
          MFS_SEL_RX_ALL:  st_next.rdata = cnt_val[MFS_CNT_RX_ALL];
          MFS_SEL_RX_GOOD: st_next.rdata = cnt_val[MFS_CNT_RX_GOOD];
          MFS_SEL_TX_ALL:  st_next.rdata = cnt_val[MFS_CNT_TX_ALL];
          MFS_SEL_STATUS: begin
            st_next.rdata[MFS_STAT_FILLED_BIT] =
              (rsvd_now == MFS_RSVD_FILLED);
          end
          MFS_SEL_NONE:    st_next.rdata = MFS_RDATA_NONE;
        endcase
      end
    end
  end

  // Single register stage for the whole slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.wr_sel   <= MFS_SEL_NONE;
      st_reg.wr_pend  <= 1'b0;
      st_reg.wr_lanes <= 4'h0;
      st_reg.rdata    <= MFS_RDATA_NONE;
      st_reg.rsvd     <= MFS_RST_RSVD_CTRL;
      st_reg.ready    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops, hresp tied to OKAY; never stall, always OKAY
  assign hrdata            = st_reg.rdata;
  assign hreadyout         = st_reg.ready;
  assign hresp             = MFS_HRESP_OKAY;
  assign mac_reserved_ctrl = st_reg.rsvd;

  // Helper for the checks: first cycle after reset release
  logic       seen_reg;
  logic       rd_pend_reg;
  mfs_sel_t   rd_sel_reg;
  logic [31:0] rd_snap_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_reg    <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_sel_reg  <= MFS_SEL_NONE;
      rd_snap_reg <= MFS_RDATA_NONE;
    end else begin
      seen_reg    <= 1'b1;
      rd_pend_reg <= addr_phase & ~hwrite;
      rd_sel_reg  <= addr_sel;
      rd_snap_reg <= cnt_val[MFS_CNT_TX_ALL];
    end
  end

  // All-received count steps by one per frame, else holds
  property p_rx_all_step;
    @(posedge hclk) disable iff (!hresetn)
    cnt_inc[MFS_CNT_RX_ALL] |=>
      cnt_val[MFS_CNT_RX_ALL] ==
      $past(cnt_val[MFS_CNT_RX_ALL]) + 32'h0000_0001;
  endproperty
  a_rx_all_step: assert property (p_rx_all_step)
    else $error("rx all count did not step by one");

  // All-received count holds in any cycle without a received frame
  property p_rx_all_hold;
    @(posedge hclk) disable iff (!hresetn)
    !frame_evt.rx_done |=> $stable(cnt_val[MFS_CNT_RX_ALL]);
  endproperty
  a_rx_all_hold: assert property (p_rx_all_hold)
    else $error("rx all count moved without a received frame");

  // Good count steps by one per valid received frame
  property p_rx_good_step;
    @(posedge hclk) disable iff (!hresetn)
    cnt_inc[MFS_CNT_RX_GOOD] |=>
      cnt_val[MFS_CNT_RX_GOOD] ==
      $past(cnt_val[MFS_CNT_RX_GOOD]) + 32'h0000_0001;
  endproperty
  a_rx_good_step: assert property (p_rx_good_step)
    else $error("rx good count did not step by one");

  // Good count moves only with a valid received frame
  property p_rx_good_only_valid;
    @(posedge hclk) disable iff (!hresetn)
    !(frame_evt.rx_done && frame_evt.rx_valid) |=>
      $stable(cnt_val[MFS_CNT_RX_GOOD]);
  endproperty
  a_rx_good_only_valid: assert property (p_rx_good_only_valid)
    else $error("rx good count moved without a valid frame");

  // Counts read zero in the first cycle after reset release
  property p_zero_after_reset;
    @(posedge hclk) disable iff (!hresetn)
    !seen_reg |-> (cnt_val[MFS_CNT_RX_ALL] == MFS_RST_COUNT &&
                   cnt_val[MFS_CNT_RX_GOOD] == MFS_RST_COUNT &&
                   cnt_val[MFS_CNT_TX_ALL] == MFS_RST_COUNT);
  endproperty
  a_zero_after_reset: assert property (p_zero_after_reset)
    else $error("count not zero after reset");

  // Wrap from maximum to zero for every counter
  property p_wrap(int unsigned k);
    @(posedge hclk) disable iff (!hresetn)
    (cnt_val[k] == MFS_COUNT_MAX && cnt_inc[k]) |=>
      cnt_val[k] == MFS_RST_COUNT;
  endproperty
  a_wrap_rx: assert property (p_wrap(MFS_CNT_RX_ALL))
    else $error("rx all count did not wrap to zero");
  a_wrap_tx: assert property (p_wrap(MFS_CNT_TX_ALL))
    else $error("tx count did not wrap to zero");
  a_wrap_good: assert property (p_wrap(MFS_CNT_RX_GOOD))
    else $error("rx good count did not wrap to zero");

  // Read of the tx count returns the value at the address phase
  property p_tx_read;
    @(posedge hclk) disable iff (!hresetn)
    (rd_pend_reg && rd_sel_reg == MFS_SEL_TX_ALL) |->
      hrdata == rd_snap_reg && hreadyout && hresp == MFS_HRESP_OKAY;
  endproperty
  a_tx_read: assert property (p_tx_read)
    else $error("tx count read returned wrong data");

  // Transmit count steps by one per sent frame that is followed by a cycle without one
  property p_tx_step;
    @(posedge hclk) disable iff (!hresetn)
    frame_evt.tx_done ##1 !frame_evt.tx_done |=>
      cnt_val[MFS_CNT_TX_ALL] ==
      $past(cnt_val[MFS_CNT_TX_ALL], 2) + 32'h0000_0001;
  endproperty
  a_tx_step: assert property (p_tx_step)
    else $error("tx count did not step by one");

  // Transmit count holds in any cycle without a sent frame
  property p_tx_hold;
    @(posedge hclk) disable iff (!hresetn)
    !frame_evt.tx_done |=> $stable(cnt_val[MFS_CNT_TX_ALL]);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx count moved without a sent frame");

  // A write data phase to the all-received count leaves it alone without a received frame
  property p_write_ignored;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_sel == MFS_SEL_RX_ALL &&
     !frame_evt.rx_done) |=> $stable(cnt_val[MFS_CNT_RX_ALL]);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed a statistics count");

  // A count only ever holds or steps by one: no clear but reset
  property p_no_clear(int unsigned k);
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> (cnt_val[k] == $past(cnt_val[k]) ||
              cnt_val[k] == $past(cnt_val[k]) + 32'h0000_0001);
  endproperty
  a_no_clear_rx: assert property (p_no_clear(MFS_CNT_RX_ALL))
    else $error("rx all count cleared outside reset");
  a_no_clear_good: assert property (p_no_clear(MFS_CNT_RX_GOOD))
    else $error("rx good count cleared outside reset");
  a_no_clear_tx: assert property (p_no_clear(MFS_CNT_TX_ALL))
    else $error("tx count cleared outside reset");

  // A full-word write data phase lands whole in the reserved word
  property p_rsvd_write;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_sel == MFS_SEL_RSVD &&
     st_reg.wr_lanes == 4'hf) |=> mac_reserved_ctrl == $past(hwdata);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("reserved word did not take the written data");

  // Main scenarios
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    cnt_val[MFS_CNT_RX_ALL] == MFS_COUNT_MAX ##1
    cnt_val[MFS_CNT_RX_ALL] == MFS_RST_COUNT);
  c_tx_read: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_reg && rd_sel_reg == MFS_SEL_TX_ALL);
  c_rsvd_filled: cover property (@(posedge hclk) disable iff (!hresetn)
    mac_reserved_ctrl == MFS_RSVD_FILLED);
  c_bad_frame: cover property (@(posedge hclk) disable iff (!hresetn)
    frame_evt.rx_done && !frame_evt.rx_valid);

endmodule

// >>> verif/tb.sv
// Self-checking bench of the frame statistics counter bank
`timescale 1ns/1ns
module tb;
  import mfs_pkg::*;

  localparam logic [31:0] A_RSVD = 32'(MFS_OFS_RSVD_CTRL);
  localparam logic [31:0] A_RXA  = 32'(MFS_OFS_RX_ALL);
  localparam logic [31:0] A_RXG  = 32'(MFS_OFS_RX_GOOD);
  localparam logic [31:0] A_TXA  = 32'(MFS_OFS_TX_ALL);
  localparam logic [31:0] A_STAT = 32'(MFS_OFS_STATUS);

  logic           hclk;
  logic           hresetn;
  logic           hsel;
  logic [31:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [2:0]     hsize;
  logic [31:0]    hwdata;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  mfs_frame_evt_t frame_evt;
  logic [31:0]    mac_reserved_ctrl;
  logic [31:0]    exp_q[$];
  logic [31:0]    e_cnt[3];
  logic [31:0]    rsv;
  logic           rd_dp;
  int             n_fail;
  int             comparisons;
  int             cyc;

  // Free-running clock, 8 ns period
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // Single slave: its hreadyout is the bus hready
  mfs_stats_top i_mfs_stats_top (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hready            (hreadyout),
    .hwdata            (hwdata),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .frame_evt         (frame_evt),
    .mac_reserved_ctrl (mac_reserved_ctrl)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One AHB single transfer; waits for hready in both phases
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    htrans <= MFS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Reads leave their expectation with the watcher
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, 32'h0, 3'h2);
  endtask

  task automatic chk_ctrl(input logic [31:0] exp);
    @(negedge hclk);
    chk(mac_reserved_ctrl, exp);
    chk({31'h0, hreadyout}, 32'h1);
    @(posedge hclk);
  endtask

  task automatic rd_counts();
    rd(A_RXA, e_cnt[MFS_CNT_RX_ALL]);
    rd(A_RXG, e_cnt[MFS_CNT_RX_GOOD]);
    rd(A_TXA, e_cnt[MFS_CNT_TX_ALL]);
  endtask

  // Every word, two unmapped places (one aliasing 0x200 above 4 KiB)
  task automatic rd_all(input logic [31:0] r, input logic st);
    rd_counts();
    rd(A_RSVD, r);
    rd(A_STAT, {31'h0, st});
    rd(32'h0000_0204 + 32'h0f0, 32'h0);
    rd(32'h0001_0200, 32'h0);
    chk_ctrl(r);
  endtask

  // Frame pulses: all eight codes in turn, or random; model wraps at 2^32
  task automatic events(input int n, input logic rnd);
    mfs_frame_evt_t ev;
    for (int i = 0; i < n; i++) begin
      ev = rnd ? mfs_frame_evt_t'(3'($urandom)) : mfs_frame_evt_t'(3'(i));
      frame_evt <= ev;
      if (ev.rx_done) e_cnt[MFS_CNT_RX_ALL]++;
      if (ev.rx_done && ev.rx_valid) e_cnt[MFS_CNT_RX_GOOD]++;
      if (ev.tx_done) e_cnt[MFS_CNT_TX_ALL]++;
      @(posedge hclk);
    end
    frame_evt <= '0;
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (e_cnt[i]) e_cnt[i] = 32'h0;
  endtask

  // Watcher: each completed read takes the oldest note
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
    end else if (hreadyout === 1'b1) begin
      if (rd_dp && exp_q.size() > 0) begin
        chk(hrdata, exp_q.pop_front());
        chk(32'(hresp), 32'(MFS_HRESP_OKAY));
      end
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      print_verdict();
    end
  end

  // Main sequence; a full count wrap needs 2^32 events, so it is not run
  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    frame_evt = '0;
    hresetn = 1'b0;
    rsv = 32'h0;
    void'($urandom(32'h7589));
    do_reset();
    rd_all(32'h0, 1'b0);
    // One more byte of ones per whole-word write, each read behind it
    for (int i = 0; i < 4; i++) begin
      rsv = rsv | (32'hff << (8 * i));
      xfer(1'b1, A_RSVD, rsv, 3'h2);
      rd(A_RSVD, rsv);
      rd(A_STAT, {31'h0, i == 3});
    end
    events(8, 1'b0);
    rd_counts();
    events(300, 1'b1);
    rd_counts();
    // Software writes must not disturb any count
    xfer(1'b1, A_RXA, $urandom, 3'h2);
    xfer(1'b1, A_RXG, 32'h0, 3'h2);
    xfer(1'b1, A_TXA, $urandom, 3'h2);
    xfer(1'b1, A_STAT, 32'h0, 3'h2);
    rd_all(rsv, 1'b1);
    events(50, 1'b1);
    // Second reset in mid-run clears counts and the control word
    do_reset();
    rd_all(32'h0, 1'b0);
    repeat (3) @(posedge hclk);
    chk(32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule
